// File: hw/sacs_pkg.sv
// shared constants and types for the sar conversion sequencer
package sacs_pkg;
   // register word indices; byte address is four times the index
   localparam logic [15:0] IDX_SC1 = 16'h0010;
   localparam logic [15:0] IDX_SC2 = 16'h0011;
   localparam logic [15:0] IDX_SC3 = 16'h0012;
   localparam logic [15:0] IDX_SC4 = 16'h0013;
   localparam logic [15:0] IDX_RH = 16'h0014;
   localparam logic [15:0] IDX_RL = 16'h0015;
   localparam logic [15:0] IDX_CVH = 16'h0016;
   localparam logic [15:0] IDX_CVL = 16'h0017;
   localparam logic [15:0] IDX_APSEL_LO = 16'h30AC;
   localparam logic [15:0] IDX_APSEL_HI = 16'h30AD;
   localparam int IDX_LSB = 2;
   localparam int IDX_W = 16;
   // status_control_1 fields
   localparam int SC1_DONE_BIT = 7;
   localparam int SC1_IRQEN_BIT = 6;
   localparam int SC1_CONT_BIT = 5;
   localparam logic [4:0] SC1_CH_RESET = 5'h1F;
   localparam logic [4:0] CH_DISABLED = 5'h1F;
   // status_control_2 fields
   localparam int SC2_ACTIVE_BIT = 7;
   localparam int SC2_HWSEL_BIT = 6;
   localparam int SC2_CMPEN_BIT = 5;
   localparam int SC2_CMPGT_BIT = 4;
   // status_control_3 fields
   localparam int SC3_DIV_LSB = 5;
   localparam int SC3_MODE_LSB = 2;
   localparam int SC3_SRC_LSB = 0;
   localparam logic [7:0] SC3_RESET = 8'h00;
   // pin select upper implemented width
   localparam int APSEL_HI_W = 4;
   // fifo
   localparam int FIFO_DEPTH_MAX = 8;
   localparam int FIFO_PTR_W = 3;
   // bus
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_IDLE = 3'b010,
      ST_BUSY = 3'b100
   } sacs_state_t;

   typedef enum logic [1:0] {
      MODE_8 = 2'b00,
      MODE_10 = 2'b01,
      MODE_12 = 2'b10
   } sacs_mode_t;

   typedef enum logic [1:0] {
      SRC_BUS = 2'b00,
      SRC_BUS_HALF = 2'b01,
      SRC_ALT = 2'b10,
      SRC_ASYNC = 2'b11
   } sacs_src_t;

   typedef struct packed {
      logic [4:0] channel;
      sacs_mode_t mode;
   } sacs_conv_req_t;

   typedef struct packed {
      logic [IDX_W-1:0] idx;
      logic write;
   } sacs_bus_cmd_t;
endpackage

// File: hw/sacs_trig_edge.sv
// trigger synchroniser and rising edge detector
`timescale 1ns/10ps
`default_nettype none
module sacs_trig_edge (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_trig,
   output logic o_rise
);
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
         o_rise <= 1'b0;
      end else begin
         sync1_reg <= i_trig;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
         o_rise <= sync2_reg & ~prev_reg;
      end
   end
endmodule // sacs_trig_edge
`default_nettype wire

// File: hw/sacs_clk_div.sv
// converter clock source select and divider, as enable pulses
`timescale 1ns/10ps
`default_nettype none
module sacs_clk_div (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_run,
   input wire logic [1:0] i_src,
   input wire logic [1:0] i_div,
   input wire logic i_alt_tick,
   input wire logic i_async_tick,
   output logic o_tick
);
   import sacs_pkg::*;
   logic half_reg;
   logic [2:0] cnt_reg;
   logic src_tick;
   logic [2:0] limit;

   // source pick
   always_comb begin
      case (sacs_src_t'(i_src))
         SRC_BUS: src_tick = 1'b1;
         SRC_BUS_HALF: src_tick = half_reg;
         SRC_ALT: src_tick = i_alt_tick;
         SRC_ASYNC: src_tick = i_async_tick;
         default: src_tick = 1'b1;
      endcase
      limit = 3'((4'h1 << i_div) - 4'h1);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         half_reg <= 1'b0;
         cnt_reg <= 3'h0;
         o_tick <= 1'b0;
      end else if (!i_run) begin
         half_reg <= 1'b0;
         cnt_reg <= 3'h0;
         o_tick <= 1'b0;
      end else begin
         half_reg <= ~half_reg;
         o_tick <= 1'b0;
         if (src_tick) begin
            if (cnt_reg >= limit) begin
               cnt_reg <= 3'h0;
               o_tick <= 1'b1;
            end else begin
               cnt_reg <= cnt_reg + 3'h1;
            end
         end
      end
   end
endmodule // sacs_clk_div
`default_nettype wire

// File: hw/sacs_seq.sv
// sar converter sequencer top: registers, starts, result transfer, blocking
`timescale 1ns/10ps
`default_nettype none
// Contract
// - disabled in reset or channel all ones with fifo off
// - idle, low power after conversion ends
// - 12/10/8 bit results, rounded and placed
// - transfer sets done flag (fifo: last result only), irq if enabled
// - compare enable blocks compare-false results with fifo off; fifo transfers them
// - four clock sources, bus clock default
// - async clock keeps running in wait/stop
// - divide converter clock by 1,2,4,8
// - analog pin: high-z, input off, reads zero
// - upper pin select bits 3..0, channels 11..8
// - hw trigger rising edge starts conversion
// - trigger edge during conversion ignored
// - continuous hw mode: only first edge acts
// - software write of channel starts conversion
// - continuous mode restarts on each transfer
// - high read blocks transfer until low read
// - single compare-false conversion stops despite blocking
// - other blocked transfers start another conversion
// - fifo mode holds channel while blocked
// - no read interlock in 8-bit mode
// - control writes abort, results keep values
module sacs_seq (
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic I_HSEL,
   input wire logic [31:0] I_HADDR,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic [2:0] I_HSIZE,
   input wire logic [31:0] I_HWDATA,
   input wire logic I_HREADY,
   output logic [31:0] O_HRDATA,
   output logic O_HREADYOUT,
   output logic O_HRESP,
   input wire logic I_HW_TRIGGER,
   input wire logic I_ALT_CLK_TICK,
   input wire logic I_ASYNC_CLK_TICK,
   input wire logic I_STOP_MODE,
   input wire logic I_CONV_DONE,
   input wire logic [11:0] I_CONV_RESULT,
   input wire logic [11:0] I_PORT_IN,
   output logic O_CONV_ENABLE,
   output logic O_CONV_START,
   output logic O_CONV_ABORT,
   output sacs_pkg::sacs_conv_req_t O_CONV_REQ,
   output logic O_CONV_CLK_TICK,
   output logic O_ASYNC_CLK_EN,
   output logic O_CONV_ACTIVE,
   output logic O_IRQ,
   output logic [11:0] O_PIN_ANALOG,
   output logic [11:0] O_PORT_IN
);
   import sacs_pkg::*;

   sacs_bus_cmd_t cmd_reg;
   logic wr_pend_reg, rd_pend_reg;
   logic [7:0] wdata, rd_byte;
   logic acc;
   logic wr_sc1, wr_sc2, wr_sc3, wr_sc4, wr_cvh, wr_cvl, rd_rh, rd_rl;
   logic irq_en_reg, cont_reg, hw_sel_reg, cmp_en_reg, cmp_gt_reg;
   logic [4:0] ch_reg;
   logic [7:0] sc3_reg;
   logic [FIFO_PTR_W-1:0] depth_reg;
   logic [3:0] cvh_reg;
   logic [7:0] cvl_reg, apsel_lo_reg;
   logic [APSEL_HI_W-1:0] apsel_hi_reg;
   sacs_state_t state_reg, state_next;
   logic done_flag_reg, block_reg, cont_run_reg;
   logic [11:0] result_reg, rd_val;
   logic [4:0] chan_mem [FIFO_DEPTH_MAX];
   logic [11:0] res_mem [FIFO_DEPTH_MAX];
   logic [FIFO_PTR_W:0] fill_reg, fill_next;
   logic [FIFO_PTR_W-1:0] conv_idx_reg, conv_idx_next, rd_idx_reg;
   sacs_mode_t mode;
   logic fifo_on, busy, trig_rise, disabled;
   logic sw_start, hw_start, start_any, cfg_abort, done_ev, last_conv;
   logic cmp_ok, cmp_fail, xfer, restart, flag_set, flag_clr;
   logic [11:0] rounded, placed, cmp_val;
   logic [12:0] sum10, sum8;

   sacs_trig_edge u_trig (
      .i_clk(I_CLK_SYS),
      .i_arst_n(I_ARST_N),
      .i_trig(I_HW_TRIGGER),
      .o_rise(trig_rise)
   );

   sacs_clk_div u_div (
      .i_clk(I_CLK_SYS),
      .i_arst_n(I_ARST_N),
      .i_run(busy),
      .i_src(sc3_reg[SC3_SRC_LSB +: 2]),
      .i_div(sc3_reg[SC3_DIV_LSB +: 2]),
      .i_alt_tick(I_ALT_CLK_TICK),
      .i_async_tick(I_ASYNC_CLK_TICK),
      .o_tick(O_CONV_CLK_TICK)
   );

   // bus slave: writes zero wait, reads one wait state
   assign acc = I_HSEL & I_HTRANS[1] & I_HREADY & (I_HSIZE == HSIZE_WORD);
   assign wdata = I_HWDATA[7:0];

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         cmd_reg <= '0;
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         O_HREADYOUT <= 1'b1;
         O_HRDATA <= 32'h0;
         O_HRESP <= 1'b0;
      end else begin
         if (acc) begin
            cmd_reg <= '{idx: I_HADDR[IDX_LSB +: IDX_W], write: I_HWRITE};
         end
         wr_pend_reg <= acc & I_HWRITE;
         rd_pend_reg <= acc & ~I_HWRITE;
         O_HREADYOUT <= ~(acc & ~I_HWRITE);
         if (rd_pend_reg) begin
            O_HRDATA <= {24'h0, rd_byte};
         end
      end
   end

   always_comb begin
      wr_sc1 = wr_pend_reg & (cmd_reg.idx == IDX_SC1);
      wr_sc2 = wr_pend_reg & (cmd_reg.idx == IDX_SC2);
      wr_sc3 = wr_pend_reg & (cmd_reg.idx == IDX_SC3);
      wr_sc4 = wr_pend_reg & (cmd_reg.idx == IDX_SC4);
      wr_cvh = wr_pend_reg & (cmd_reg.idx == IDX_CVH);
      wr_cvl = wr_pend_reg & (cmd_reg.idx == IDX_CVL);
      rd_rh = rd_pend_reg & (cmd_reg.idx == IDX_RH);
      rd_rl = rd_pend_reg & (cmd_reg.idx == IDX_RL);
   end

   always_comb begin
      case (cmd_reg.idx)
         IDX_SC1: rd_byte = {done_flag_reg, irq_en_reg, cont_reg, ch_reg};
         IDX_SC2: rd_byte = {busy, hw_sel_reg, cmp_en_reg, cmp_gt_reg, 4'h0};
         IDX_SC3: rd_byte = sc3_reg;
         IDX_SC4: rd_byte = {5'h0, depth_reg};
         IDX_RH: rd_byte = {4'h0, rd_val[11:8]};
         IDX_RL: rd_byte = rd_val[7:0];
         IDX_CVH: rd_byte = {4'h0, cvh_reg};
         IDX_CVL: rd_byte = cvl_reg;
         IDX_APSEL_LO: rd_byte = apsel_lo_reg;
         IDX_APSEL_HI: rd_byte = {4'h0, apsel_hi_reg};
         default: rd_byte = 8'h00;
      endcase
   end

   // control registers
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         irq_en_reg <= 1'b0;
         cont_reg <= 1'b0;
         ch_reg <= SC1_CH_RESET;
         hw_sel_reg <= 1'b0;
         cmp_en_reg <= 1'b0;
         cmp_gt_reg <= 1'b0;
         sc3_reg <= SC3_RESET;
         depth_reg <= '0;
         cvh_reg <= 4'h0;
         cvl_reg <= 8'h00;
         apsel_lo_reg <= 8'h00;
         apsel_hi_reg <= '0;
      end else begin
         if (wr_sc1) begin
            irq_en_reg <= wdata[SC1_IRQEN_BIT];
            cont_reg <= wdata[SC1_CONT_BIT];
            ch_reg <= wdata[4:0];
         end
         if (wr_sc2) begin
            hw_sel_reg <= wdata[SC2_HWSEL_BIT];
            cmp_en_reg <= wdata[SC2_CMPEN_BIT];
            cmp_gt_reg <= wdata[SC2_CMPGT_BIT];
         end
         if (wr_sc3) begin
            sc3_reg <= wdata;
         end
         if (wr_sc4) begin
            depth_reg <= wdata[FIFO_PTR_W-1:0];
         end
         if (wr_cvh) begin
            cvh_reg <= wdata[3:0];
         end
         if (wr_cvl) begin
            cvl_reg <= wdata;
         end
         if (wr_pend_reg && cmd_reg.idx == IDX_APSEL_LO) begin
            apsel_lo_reg <= wdata;
         end
         if (wr_pend_reg && cmd_reg.idx == IDX_APSEL_HI) begin
            apsel_hi_reg <= wdata[APSEL_HI_W-1:0];
         end
      end
   end

   // result rounding, placement and compare
   always_comb begin
      mode = sacs_mode_t'(sc3_reg[SC3_MODE_LSB +: 2]);
      sum10 = {1'b0, I_CONV_RESULT} + 13'h0002;
      sum8 = {1'b0, I_CONV_RESULT} + 13'h0008;
      case (mode)
         MODE_10: rounded = sum10[12] ? 12'h3FF : {2'h0, sum10[11:2]};
         MODE_8: rounded = sum8[12] ? 12'h0FF : {4'h0, sum8[11:4]};
         default: rounded = I_CONV_RESULT;
      endcase
      cmp_val = {cvh_reg, cvl_reg};
      cmp_ok = cmp_gt_reg ? (rounded >= cmp_val) : (rounded < cmp_val);
      cmp_fail = cmp_en_reg & ~cmp_ok;
      placed = cmp_en_reg ? (rounded - cmp_val) : rounded;
   end

   // sequencing decisions
   always_comb begin
      fifo_on = (depth_reg != '0);
      busy = (state_reg == ST_BUSY);
      disabled = ((wr_sc1 ? wdata[4:0] : ch_reg) == CH_DISABLED) & ~fifo_on;
      if (wr_sc1 && fifo_on) begin
         fill_next = (fill_reg >= {1'b0, depth_reg}) ? 4'h1 : fill_reg + 4'h1;
      end else if (wr_sc4) begin
         fill_next = '0;
      end else begin
         fill_next = fill_reg;
      end
      sw_start = wr_sc1 & ~hw_sel_reg &
                 (fifo_on ? (fill_next == {1'b0, depth_reg}) : (wdata[4:0] != CH_DISABLED));
      hw_start = trig_rise & hw_sel_reg & (state_reg == ST_IDLE) & ~cont_run_reg &
                 (~fifo_on | (fill_reg == {1'b0, depth_reg}));
      cfg_abort = wr_sc1 | wr_sc2 | wr_sc3 | wr_sc4 | wr_cvh | wr_cvl |
                  (I_STOP_MODE & (sc3_reg[SC3_SRC_LSB +: 2] != SRC_ASYNC));
      start_any = sw_start | (hw_start & ~cfg_abort);
      done_ev = I_CONV_DONE & busy & ~cfg_abort;
      last_conv = (conv_idx_reg == depth_reg - 3'h1);
      if (fifo_on) begin
         xfer = ~block_reg;
         restart = block_reg | ~last_conv | cont_reg;
         flag_set = done_ev & ~block_reg & last_conv;
      end else begin
         xfer = ~cmp_fail & ~block_reg;
         restart = cont_reg | (block_reg & ~cmp_fail);
         flag_set = done_ev & xfer;
      end
      conv_idx_next = conv_idx_reg;
      if (start_any) begin
         conv_idx_next = '0;
      end else if (done_ev && fifo_on && !block_reg) begin
         conv_idx_next = last_conv ? '0 : conv_idx_reg + 3'h1;
      end
      flag_clr = wr_sc1 | (rd_rl & ~fifo_on);
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_OFF: if (!disabled) state_next = start_any ? ST_BUSY : ST_IDLE;
         ST_IDLE: if (disabled) state_next = ST_OFF;
                  else if (start_any) state_next = ST_BUSY;
         ST_BUSY: if (disabled) state_next = ST_OFF;
                  else if (start_any) state_next = ST_BUSY;
                  else if (cfg_abort) state_next = ST_IDLE;
                  else if (done_ev && !restart) state_next = ST_IDLE;
         default: state_next = ST_OFF;
      endcase
   end

   // state and converter handshake
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_reg <= ST_OFF;
         cont_run_reg <= 1'b0;
         O_CONV_START <= 1'b0;
         O_CONV_ABORT <= 1'b0;
         O_CONV_REQ <= '{channel: CH_DISABLED, mode: MODE_8};
         O_CONV_ENABLE <= 1'b0;
         O_CONV_ACTIVE <= 1'b0;
         O_ASYNC_CLK_EN <= 1'b0;
      end else begin
         state_reg <= state_next;
         O_CONV_START <= (start_any | (done_ev & restart)) & ~disabled;
         O_CONV_ABORT <= busy & (cfg_abort | disabled);
         O_CONV_REQ.mode <= mode;
         O_CONV_REQ.channel <= fifo_on ? chan_mem[conv_idx_next] : ch_reg;
         if (wr_sc1 && !fifo_on) begin
            O_CONV_REQ.channel <= wdata[4:0];
         end
         if (start_any) begin
            cont_run_reg <= cont_reg;
         end else if (state_next != ST_BUSY) begin
            cont_run_reg <= 1'b0;
         end
         O_CONV_ENABLE <= ~disabled;
         O_CONV_ACTIVE <= (state_next == ST_BUSY);
         O_ASYNC_CLK_EN <= (state_next == ST_BUSY) &
                           (sc3_reg[SC3_SRC_LSB +: 2] == SRC_ASYNC);
      end
   end

   // fifo storage
   always_ff @(posedge I_CLK_SYS) begin
      if (wr_sc1 && fifo_on) begin
         chan_mem[fill_next[FIFO_PTR_W-1:0] - 3'h1] <= wdata[4:0];
      end
      if (done_ev && fifo_on && xfer) begin
         res_mem[conv_idx_reg] <= placed;
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         fill_reg <= '0;
         conv_idx_reg <= '0;
         rd_idx_reg <= '0;
      end else begin
         fill_reg <= fill_next;
         conv_idx_reg <= conv_idx_next;
         if (start_any) begin
            rd_idx_reg <= '0;
         end else if (rd_rl && fifo_on) begin
            rd_idx_reg <= (rd_idx_reg == depth_reg - 3'h1) ? '0 : rd_idx_reg + 3'h1;
         end
      end
   end

   assign rd_val = fifo_on ? res_mem[rd_idx_reg] : result_reg;

   // result registers keep their value on abort
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         result_reg <= 12'h000;
      end else if (done_ev && !fifo_on && xfer) begin
         result_reg <= placed;
      end
   end

   // read interlock
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         block_reg <= 1'b0;
      end else if (mode == MODE_8) begin
         block_reg <= 1'b0;
      end else if (rd_rh) begin
         block_reg <= 1'b1;
      end else if (rd_rl) begin
         block_reg <= 1'b0;
      end
   end

   // done flag and interrupt, set wins over clear
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         done_flag_reg <= 1'b0;
         O_IRQ <= 1'b0;
      end else if (flag_set) begin
         done_flag_reg <= 1'b1;
         O_IRQ <= irq_en_reg;
      end else if (flag_clr) begin
         done_flag_reg <= 1'b0;
         O_IRQ <= 1'b0;
      end
   end

   // analog pin takeover
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         O_PIN_ANALOG <= 12'h000;
         O_PORT_IN <= 12'h000;
      end else begin
         O_PIN_ANALOG <= {apsel_hi_reg, apsel_lo_reg};
         O_PORT_IN <= I_PORT_IN & ~{apsel_hi_reg, apsel_lo_reg};
      end
   end
endmodule // sacs_seq
`default_nettype wire

// File: dv/sacs_seq_asserts.sv
// port checker for the sar conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sacs_seq_asserts (
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic I_HSEL,
   input wire logic [1:0] I_HTRANS,
   input wire logic I_HWRITE,
   input wire logic I_HREADY,
   input wire logic I_CONV_DONE,
   input wire logic I_STOP_MODE,
   input wire logic [11:0] I_PORT_IN,
   input wire logic O_CONV_ENABLE,
   input wire logic O_CONV_START,
   input wire logic O_CONV_ABORT,
   input wire logic O_CONV_CLK_TICK,
   input wire logic O_ASYNC_CLK_EN,
   input wire logic O_CONV_ACTIVE,
   input wire logic O_IRQ,
   input wire logic [11:0] O_PIN_ANALOG,
   input wire logic [11:0] O_PORT_IN
);
   logic [2:0] live_reg;
   logic wr_reg;
   // marks the cycles that follow the release of reset
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         live_reg <= 3'h0;
      end else begin
         live_reg <= {live_reg[1:0], 1'b1};
      end
   end
   // high during the data phase of a write
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         wr_reg <= 1'b0;
      end else begin
         wr_reg <= I_HSEL && I_HTRANS[1] && I_HWRITE && I_HREADY;
      end
   end
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_ARST_N);
   sequence s_done_ok;
      O_CONV_ACTIVE && I_CONV_DONE && !O_CONV_ABORT;
   endsequence
   a_start_enabled: assert property (O_CONV_START |-> O_CONV_ENABLE)
      else $error("conversion start while disabled");
   a_done_idle: assert property (s_done_ok ##1 !O_CONV_START |-> !O_CONV_ACTIVE)
      else $error("still active after a finished conversion");
   a_start_active: assert property (O_CONV_START |-> O_CONV_ACTIVE)
      else $error("start without active");
   a_irq_cause: assert property ($rose(O_IRQ) |-> $past(I_CONV_DONE) && $past(O_CONV_ACTIVE))
      else $error("interrupt without a completed conversion");
   a_port_mask: assert property (live_reg[2] |-> O_PORT_IN == ($past(I_PORT_IN) & ~O_PIN_ANALOG))
      else $error("port read not masked on analog pins");
   a_tick_busy: assert property (O_CONV_CLK_TICK |-> O_CONV_ACTIVE || $past(O_CONV_ACTIVE))
      else $error("converter clock tick while idle");
   a_pins_hold: assert property (live_reg[2] && !$past(wr_reg) |=> $stable(O_PIN_ANALOG))
      else $error("pin select changed without a write");
   a_async_stop: assert property (O_CONV_ACTIVE && I_STOP_MODE && O_ASYNC_CLK_EN |=> !O_CONV_ABORT)
      else $error("stop aborted an async clocked conversion");
endmodule // sacs_seq_asserts
`default_nettype wire

// File: dv/sacs_core_model.sv
// behavioural converter core: answers the latest start after a set latency unless aborted
`timescale 1ns/10ps
`default_nettype none
module sacs_core_model (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic i_abort,
   input wire logic [7:0] i_lat,
   input wire logic [11:0] i_res,
   output logic o_done,
   output logic [11:0] o_result
);
   logic [7:0] cnt_reg;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_reg <= 8'h00;
         o_done <= 1'b0;
         o_result <= 12'h000;
      end else begin
         o_done <= 1'b0;
         o_result <= ~o_result; // result lines are not held outside the done cycle
         if (i_start) begin
            cnt_reg <= i_lat;
         end else if (i_abort) begin
            cnt_reg <= 8'h00;
         end else if (cnt_reg == 8'h01) begin
            cnt_reg <= 8'h00;
            o_done <= 1'b1;
            o_result <= i_res;
         end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
         end
      end
   end
endmodule // sacs_core_model
`default_nettype wire

// File: dv/sacs_seq_tb_top.sv
// self-checking bench for the sar conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module sacs_seq_tb_top;
   import sacs_pkg::*;
   logic clk, rst_n, hwrite, trig, stop, hready, hresp, done, en, st, ab, tick, aen, act, irq;
   logic alt = 1'b0, asy = 1'b0;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [11:0] pin, res, cres, pan, pout;
   logic [7:0] lat;
   sacs_conv_req_t req;
   int miscompares = 0, samples_checked = 0, starts = 0, aborts = 0, dones = 0, ticks = 0;
   int cnt = 0, t0, t1;
   logic [7:0] md [3] = '{8'h08, 8'h04, 8'h00};
   logic [11:0] rw [3] = '{12'hABC, 12'hABE, 12'hAB8};
   logic [31:0] eh [3] = '{32'h0A, 32'h02, 32'h00};
   logic [31:0] el [3] = '{32'hBC, 32'hB0, 32'hAC};
   logic [7:0] ck [7] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h01, 8'h02, 8'h03};
   logic [31:0] ct [7] = '{32'd64, 32'd32, 32'd16, 32'd8, 32'd32, 32'd8, 32'd16};
   sacs_seq i_sacs_seq (.I_CLK_SYS(clk), .I_ARST_N(rst_n), .I_HSEL(1'b1), .I_HADDR(haddr),
      .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(HSIZE_WORD), .I_HWDATA(hwdata),
      .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
      .I_HW_TRIGGER(trig), .I_ALT_CLK_TICK(alt), .I_ASYNC_CLK_TICK(asy), .I_STOP_MODE(stop),
      .I_CONV_DONE(done), .I_CONV_RESULT(cres), .I_PORT_IN(pin), .O_CONV_ENABLE(en),
      .O_CONV_START(st), .O_CONV_ABORT(ab), .O_CONV_REQ(req), .O_CONV_CLK_TICK(tick),
      .O_ASYNC_CLK_EN(aen), .O_CONV_ACTIVE(act), .O_IRQ(irq), .O_PIN_ANALOG(pan),
      .O_PORT_IN(pout));
   sacs_core_model i_sacs_core_model (.i_clk(clk), .i_arst_n(rst_n), .i_start(st),
      .i_abort(ab), .i_lat(lat), .i_res(res), .o_done(done), .o_result(cres));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cnt <= cnt + 1;
      alt <= (cnt % 8 == 7);
      asy <= (cnt % 4 == 3);
      starts <= starts + int'(st);
      aborts <= aborts + int'(ab);
      dones <= dones + int'(done);
      ticks <= ticks + int'(tick);
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic [15:0] idx, input logic w, input logic [7:0] wd);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {14'h0, idx, 2'h0};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic bw(input logic [15:0] idx, input logic [7:0] wd);
      bus(idx, 1'b1, wd);
   endtask
   task automatic rc(input string nm, input logic [15:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 8'h00);
      chk(nm, d, exp);
   endtask
   task automatic wc();
      int n = 0;
      repeat (2) @(posedge clk);
      while (act !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      chk("idle", act, 1'h0);
   endtask
   task automatic ws(input int n);
      for (int k = 0; k < 400 && starts < n; k++) @(posedge clk);
   endtask
   task automatic pulse();
      @(posedge clk);
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      test_done();
   end
   initial begin
      rst_n = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
      trig = 1'b0; stop = 1'b0; pin = 12'hFFF; lat = 8'h14; res = 12'hABC;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      chk("enable", en, 1'h0);
      rc("sc1", IDX_SC1, 32'h1F);
      rc("sc3", IDX_SC3, {24'h0, SC3_RESET});
      rc("unmapped", 16'h0100, 32'h0);
      chk("resp", hresp, 32'h0);
      bw(IDX_APSEL_HI, 8'hFF);
      rc("apsel", IDX_APSEL_HI, 32'h0F);
      chk("analog", pan, 12'hF00);
      chk("port", pout, 12'h0FF);
      $display("test reset and pins finished");
      for (int i = 0; i < 3; i++) begin
         bw(IDX_SC3, md[i]);
         res <= rw[i];
         bw(IDX_SC1, 8'h43);
         wc();
         chk("req", req, {25'h0, 5'h03, md[i][3:2]});
         chk("irq", irq, 1'h1);
         rc("sc1", IDX_SC1, 32'hC3);
         rc("high", IDX_RH, eh[i]);
         rc("low", IDX_RL, el[i]);
         @(posedge clk);
         chk("irq", irq, 1'h0);
      end
      $display("test modes finished");
      bw(IDX_SC3, 8'h08);
      res <= 12'hABC;
      bw(IDX_SC1, 8'h03);
      wc();
      bus(IDX_RH, 1'b0, 8'h00);
      t0 = starts;
      res <= 12'h123;
      bw(IDX_SC1, 8'h03);
      ws(t0 + 2);
      chk("restart", starts - t0, 32'd2);
      res <= 12'h456;
      rc("sc1", IDX_SC1, 32'h03);
      rc("low", IDX_RL, 32'hBC);
      wc();
      rc("high", IDX_RH, 32'h04);
      rc("low", IDX_RL, 32'h56);
      $display("test interlock finished");
      t0 = starts;
      res <= 12'h321;
      bw(IDX_SC1, 8'h23);
      ws(t0 + 3);
      chk("runs", starts - t0, 32'd3);
      t0 = aborts;
      bw(IDX_SC2, 8'h00);
      repeat (3) @(posedge clk);
      chk("abort", aborts - t0, 32'd1);
      chk("active", act, 1'h0);
      rc("high", IDX_RH, 32'h03);
      rc("low", IDX_RL, 32'h21);
      $display("test continuous finished");
      lat <= 8'h28;
      bw(IDX_SC2, 8'h40);
      t0 = starts;
      bw(IDX_SC1, 8'h03);
      repeat (6) @(posedge clk);
      chk("hw only", starts - t0, 32'd0);
      pulse();
      ws(t0 + 1);
      chk("hw start", starts - t0, 32'd1);
      pulse();
      wc();
      chk("busy edge", starts - t0, 32'd1);
      t0 = starts;
      t1 = dones;
      bw(IDX_SC1, 8'h23);
      pulse();
      ws(t0 + 2);
      pulse();
      ws(t0 + 3);
      chk("cont edge", starts - t0, dones - t1 + 1);
      bw(IDX_SC2, 8'h00);
      $display("test trigger finished");
      lat <= 8'hFF;
      for (int i = 0; i < 7; i++) begin
         bw(IDX_SC3, ck[i]);
         bw(IDX_SC1, 8'h03);
         stop <= (ck[i][1:0] == 2'h3);
         repeat (4) @(posedge clk);
         t0 = ticks;
         t1 = aborts;
         repeat (64) @(posedge clk);
         chk("ticks", ticks - t0, ct[i]);
         chk("async", aen, {31'h0, ck[i][1:0] == 2'h3});
         chk("stop", aborts - t1, 32'd0);
         stop <= 1'b0;
      end
      $display("test clocks finished");
      test_done();
   end
endmodule // sacs_seq_tb_top
bind sacs_seq sacs_seq_asserts i_sacs_seq_asserts (.I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N),
   .I_HSEL(I_HSEL), .I_HTRANS(I_HTRANS), .I_HWRITE(I_HWRITE), .I_HREADY(I_HREADY),
   .I_CONV_DONE(I_CONV_DONE), .I_STOP_MODE(I_STOP_MODE), .I_PORT_IN(I_PORT_IN),
   .O_CONV_ENABLE(O_CONV_ENABLE), .O_CONV_START(O_CONV_START), .O_CONV_ABORT(O_CONV_ABORT),
   .O_CONV_CLK_TICK(O_CONV_CLK_TICK), .O_ASYNC_CLK_EN(O_ASYNC_CLK_EN),
   .O_CONV_ACTIVE(O_CONV_ACTIVE), .O_IRQ(O_IRQ), .O_PIN_ANALOG(O_PIN_ANALOG),
   .O_PORT_IN(O_PORT_IN));
`default_nettype wire
